// File: design/hpc_pkg.sv
package hpc_pkg;

    // ==========================================
    // host port function select {func_select_1, func_select_0}
    typedef enum logic [1:0] {
        HPC_SEL_PTR_LO = 2'h0,
        HPC_SEL_DATA = 2'h1,
        HPC_SEL_PTR_HI = 2'h2,
        HPC_SEL_CTL = 2'h3
    } hpc_sel_t;

    // ==========================================
    // host_control_word bit positions
    localparam int unsigned HPC_HALT_BIT = 15;
    localparam int unsigned HPC_CACHE_OFF_BIT = 14;
    localparam int unsigned HPC_LOW_BYTE_TRIGGER_BIT = 13;
    localparam int unsigned HPC_READ_AUTO_ADVANCE_BIT = 12;
    localparam int unsigned HPC_WRITE_AUTO_ADVANCE_BIT = 11;
    localparam int unsigned HPC_RESERVED_BIT = 10;
    localparam int unsigned HPC_NMI_NO_SAVE_BIT = 9;
    localparam int unsigned HPC_NMI_BIT = 8;
    localparam int unsigned HPC_HOST_IRQ_BIT = 7;
    localparam int unsigned HPC_P2H_NOTE_LSB = 4;
    localparam int unsigned HPC_PROC_IRQ_BIT = 3;
    localparam int unsigned HPC_H2P_NOTE_LSB = 0;
    localparam int unsigned HPC_NOTE_W = 3;

    // ==========================================
    // reset values and masks
    localparam logic [15:0] HPC_CTL_RESET = 16'h0000;
    localparam logic [31:0] HPC_PTR_RESET = 32'h0000_0000;
    localparam logic [15:0] HPC_DATA_RESET = 16'h0000;
    localparam logic [15:0] HPC_CTL_READ_MASK = 16'hFBFF;
    localparam logic [15:0] HPC_PTR_LO_MASK = 16'hFFF0;
    localparam logic [31:0] HPC_PTR_STEP = 32'h0000_0010;
    localparam logic [31:0] HPC_PTR_MASK = 32'hFFFF_FFF0;

    // ==========================================
    // local memory cycle sequencer states
    typedef enum logic [1:0] {
        HPC_MEM_IDLE = 2'h0,
        HPC_MEM_BUSY = 2'h1,
        HPC_MEM_DONE = 2'h3
    } hpc_mem_st_t;

endpackage

// File: design/hpc_mem_seq.sv
`timescale 1ns/1ps

module hpc_mem_seq
    import hpc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // cycle request from the host port
    input wire logic start,
    input wire logic start_we,
    input wire logic [31:0] start_addr,
    input wire logic [15:0] start_wdata,
    output logic busy,
    output logic done,
    output logic done_we,
    output logic [15:0] done_rdata,
    // local memory bus
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);

    typedef struct packed {
        hpc_mem_st_t st;
        logic req;
        logic we;
        logic [31:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic done;
    } hpc_seq_t;

    hpc_seq_t s_r;
    hpc_seq_t s_nxt;

    // ==========================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.st)
            HPC_MEM_IDLE: begin
                if (start) begin
                    s_nxt.st = HPC_MEM_BUSY;
                    s_nxt.req = 1'b1;
                    s_nxt.we = start_we;
                    s_nxt.addr = start_addr & HPC_PTR_MASK;
                    s_nxt.wdata = start_wdata;
                end
            end
            HPC_MEM_BUSY: begin
                if (mem_ack) begin
                    s_nxt.st = HPC_MEM_DONE;
                    s_nxt.req = 1'b0;
                    s_nxt.done = 1'b1;
                    if (!s_r.we) begin
                        s_nxt.rdata = mem_rdata;
                    end
                end
            end
            HPC_MEM_DONE: begin
                // one idle cycle lets the pointer update settle before the next cycle
                s_nxt.st = HPC_MEM_IDLE;
            end
            default: begin
                s_nxt.st = HPC_MEM_IDLE;
                s_nxt.req = 1'b0;
            end
        endcase
    end

    // ==========================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r <= '{st: HPC_MEM_IDLE, req: 1'b0, we: 1'b0, addr: HPC_PTR_RESET,
                     wdata: HPC_DATA_RESET, rdata: HPC_DATA_RESET, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.st != HPC_MEM_IDLE);
    assign done = s_r.done;
    assign done_we = s_r.we;
    assign done_rdata = s_r.rdata;
    assign mem_req = s_r.req;
    assign mem_we = s_r.we;
    assign mem_addr = s_r.addr;
    assign mem_wdata = s_r.wdata;

endmodule

// File: design/hpc_host_port.sv
`timescale 1ns/1ps

module hpc_host_port
    import hpc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // host port
    input wire logic host_cs_n,
    input wire logic func_select_0,
    input wire logic func_select_1,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [1:0] host_be,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    output logic host_irq_pin_n,
    // processor side of the control word
    input wire logic cpu_ctl_wr,
    input wire logic [1:0] cpu_ctl_be,
    input wire logic [15:0] cpu_ctl_wdata,
    output logic [15:0] cpu_ctl_rdata,
    output logic pending_from_host_flag,
    // processor core controls
    input wire logic instr_done,
    input wire logic nmi_taken,
    output logic exec_halted,
    output logic cache_off,
    output logic nmi_request,
    output logic nmi_no_save,
    // local memory bus
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);

    typedef struct packed {
        logic [15:0] ctl;
        logic [31:0] ptr;
        logic [15:0] data_buf;
        logic [15:0] host_rdata;
        logic [15:0] cpu_rdata;
        logic halted;
        logic irq_pin_n;
    } hpc_state_t;

    hpc_state_t s_r;
    hpc_state_t s_nxt;

    logic seq_busy;
    logic seq_done;
    logic seq_done_we;
    logic [15:0] seq_rdata;
    logic seq_start;
    logic seq_we;
    logic [31:0] seq_addr;

    // ==========================================
    // helpers
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                            input logic [1:0] be);
        merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    function automatic logic [31:0] ptr_advance(input logic [31:0] p);
        ptr_advance = (p + HPC_PTR_STEP) & HPC_PTR_MASK;
    endfunction

    // ==========================================
    // next state
    always_comb begin
        hpc_sel_t sel;
        logic hwr;
        logic hrd;
        logic trig_lane;
        logic [15:0] c;
        logic hirq_set;
        logic hirq_clr;
        logic pirq_set;
        logic pirq_clr;
        logic nmi_set;
        sel = hpc_sel_t'({func_select_1, func_select_0});
        hwr = !host_cs_n && !host_wr_n;
        hrd = !host_cs_n && host_wr_n && !host_rd_n;
        s_nxt = s_r;
        c = s_r.ctl;
        hirq_set = 1'b0;
        hirq_clr = 1'b0;
        pirq_set = 1'b0;
        pirq_clr = 1'b0;
        nmi_set = 1'b0;
        seq_start = 1'b0;
        seq_we = 1'b0;
        // an 8-bit host finishes a word on the byte chosen by low_byte_trigger
        trig_lane = s_r.ctl[HPC_LOW_BYTE_TRIGGER_BIT] ? host_be[0] : host_be[1];

        // processor writes go first so that a same-cycle host write wins shared fields
        if (cpu_ctl_wr && cpu_ctl_be[1]) begin
            c[15:11] = cpu_ctl_wdata[15:11];
            c[HPC_NMI_NO_SAVE_BIT] = cpu_ctl_wdata[HPC_NMI_NO_SAVE_BIT];
        end
        if (cpu_ctl_wr && cpu_ctl_be[0]) begin
            hirq_set = cpu_ctl_wdata[HPC_HOST_IRQ_BIT];
            c[HPC_P2H_NOTE_LSB +: HPC_NOTE_W] = cpu_ctl_wdata[HPC_P2H_NOTE_LSB +: HPC_NOTE_W];
            pirq_clr = !cpu_ctl_wdata[HPC_PROC_IRQ_BIT];
        end

        unique case (sel)
            HPC_SEL_PTR_LO: begin
                if (hwr) begin
                    s_nxt.ptr[15:0] = merge16(s_r.ptr[15:0], host_wdata, host_be) &
                                      HPC_PTR_LO_MASK;
                    seq_start = s_r.ctl[HPC_LOW_BYTE_TRIGGER_BIT] && host_be[0];
                end
            end
            HPC_SEL_PTR_HI: begin
                if (hwr) begin
                    s_nxt.ptr[31:16] = merge16(s_r.ptr[31:16], host_wdata, host_be);
                    seq_start = !s_r.ctl[HPC_LOW_BYTE_TRIGGER_BIT] && host_be[1];
                end
            end
            HPC_SEL_DATA: begin
                if (hwr) begin
                    s_nxt.data_buf = merge16(s_r.data_buf, host_wdata, host_be);
                end
                seq_start = (hwr || hrd) && trig_lane;
                seq_we = hwr;
            end
            HPC_SEL_CTL: begin
                if (hwr && host_be[1]) begin
                    c[15:11] = host_wdata[15:11];
                    c[HPC_NMI_NO_SAVE_BIT] = host_wdata[HPC_NMI_NO_SAVE_BIT];
                    nmi_set = host_wdata[HPC_NMI_BIT];
                end
                if (hwr && host_be[0]) begin
                    hirq_clr = !host_wdata[HPC_HOST_IRQ_BIT];
                    pirq_set = host_wdata[HPC_PROC_IRQ_BIT];
                    c[HPC_H2P_NOTE_LSB +: HPC_NOTE_W] = host_wdata[HPC_H2P_NOTE_LSB +: HPC_NOTE_W];
                end
            end
        endcase

        // sticky bits: a set in the same cycle as a clear wins
        c[HPC_HOST_IRQ_BIT] = (c[HPC_HOST_IRQ_BIT] & !hirq_clr) | hirq_set;
        c[HPC_PROC_IRQ_BIT] = (c[HPC_PROC_IRQ_BIT] & !pirq_clr) | pirq_set;
        c[HPC_NMI_BIT] = (c[HPC_NMI_BIT] & !nmi_taken) | nmi_set;
        c[HPC_RESERVED_BIT] = 1'b0;
        s_nxt.ctl = c;

        // local memory cycles; a trigger while a cycle is running is dropped
        seq_start = seq_start && !seq_busy;
        seq_addr = s_nxt.ptr;
        if (seq_start && !seq_we && s_r.ctl[HPC_READ_AUTO_ADVANCE_BIT]) begin
            seq_addr = ptr_advance(s_nxt.ptr);
            s_nxt.ptr = seq_addr;
        end
        if (seq_done && seq_done_we && s_r.ctl[HPC_WRITE_AUTO_ADVANCE_BIT]) begin
            s_nxt.ptr = ptr_advance(s_r.ptr);
        end
        if (seq_done && !seq_done_we) begin
            s_nxt.data_buf = seq_rdata;
        end

        // halt takes effect only at an instruction boundary
        if (!s_r.ctl[HPC_HALT_BIT]) begin
            s_nxt.halted = 1'b0;
        end else if (instr_done) begin
            s_nxt.halted = 1'b1;
        end

        s_nxt.irq_pin_n = !c[HPC_HOST_IRQ_BIT];

        unique case (sel)
            HPC_SEL_PTR_LO: s_nxt.host_rdata = s_r.ptr[15:0] & HPC_PTR_LO_MASK;
            HPC_SEL_PTR_HI: s_nxt.host_rdata = s_r.ptr[31:16];
            HPC_SEL_DATA: s_nxt.host_rdata = s_r.data_buf;
            HPC_SEL_CTL: s_nxt.host_rdata = s_r.ctl & HPC_CTL_READ_MASK;
        endcase
        s_nxt.cpu_rdata = s_r.ctl & HPC_CTL_READ_MASK;
    end

    // ==========================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r <= '{ctl: HPC_CTL_RESET, ptr: HPC_PTR_RESET, data_buf: HPC_DATA_RESET,
                     host_rdata: HPC_DATA_RESET, cpu_rdata: HPC_DATA_RESET,
                     halted: 1'b0, irq_pin_n: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // local memory sequencer
    hpc_mem_seq u_mem_seq (
        .sys_clk(sys_clk),
        .reset(reset),
        .start(seq_start),
        .start_we(seq_we),
        .start_addr(seq_addr),
        .start_wdata(s_nxt.data_buf),
        .busy(seq_busy),
        .done(seq_done),
        .done_we(seq_done_we),
        .done_rdata(seq_rdata),
        .mem_req(mem_req),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .mem_ack(mem_ack)
    );

    // ==========================================
    // outputs, all from flip-flops
    assign host_rdata = s_r.host_rdata;
    assign host_irq_pin_n = s_r.irq_pin_n;
    assign cpu_ctl_rdata = s_r.cpu_rdata;
    assign pending_from_host_flag = s_r.ctl[HPC_PROC_IRQ_BIT];
    assign exec_halted = s_r.halted;
    assign cache_off = s_r.ctl[HPC_CACHE_OFF_BIT];
    assign nmi_request = s_r.ctl[HPC_NMI_BIT];
    assign nmi_no_save = s_r.ctl[HPC_NMI_NO_SAVE_BIT];

endmodule

// File: verification/hpc_host_port_asserts.sv
`timescale 1ns/1ps

module hpc_host_port_asserts
    import hpc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // host port
    input wire logic host_cs_n,
    input wire logic func_select_0,
    input wire logic func_select_1,
    input wire logic host_wr_n,
    input wire logic [1:0] host_be,
    input wire logic [15:0] host_wdata,
    input wire logic host_irq_pin_n,
    // processor side
    input wire logic cpu_ctl_wr,
    input wire logic [1:0] cpu_ctl_be,
    input wire logic [15:0] cpu_ctl_wdata,
    input wire logic instr_done,
    input wire logic nmi_taken,
    input wire logic exec_halted,
    input wire logic cache_off,
    input wire logic nmi_request,
    // local memory bus
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic mem_ack
);
    // ==========================================
    // helpers
    logic hctl_wr;
    logic cpu_irq_set;
    assign hctl_wr = !host_cs_n && !host_wr_n && func_select_0 && func_select_1;
    assign cpu_irq_set = cpu_ctl_wr && cpu_ctl_be[0] && cpu_ctl_wdata[7];
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    sequence s_mem_wait;
        mem_req && !mem_ack;
    endsequence
    sequence s_mem_ack;
        mem_req && mem_ack;
    endsequence

    // ==========================================
    // checks
    addr_low_zero_a: assert property (mem_req |-> mem_addr[3:0] == 4'h0)
        else $error("pointer low bits not zero");
    mem_hold_a: assert property (s_mem_wait |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request dropped");
    mem_release_a: assert property (s_mem_ack |=> !mem_req)
        else $error("memory request held after ack");
    halt_wait_a: assert property ($rose(exec_halted) |-> $past(instr_done))
        else $error("halt before instruction end");
    cache_follow_a: assert property (hctl_wr && host_be[1]
        |=> cache_off == $past(host_wdata[14])) else $error("cache control wrong");
    nmi_clear_a: assert property (nmi_request && nmi_taken
        && !(hctl_wr && host_be[1] && host_wdata[8]) |=> !nmi_request)
        else $error("nmi not cleared");
    irq_pin_set_a: assert property (cpu_irq_set |=> !host_irq_pin_n)
        else $error("host irq pin not low");
    host_no_set_a: assert property (hctl_wr && host_be[0] && host_irq_pin_n
        && !cpu_irq_set |=> host_irq_pin_n) else $error("host set irq request");
endmodule

bind hpc_host_port hpc_host_port_asserts u_asserts (
    .sys_clk(sys_clk), .reset(reset), .host_cs_n(host_cs_n),
    .func_select_0(func_select_0), .func_select_1(func_select_1),
    .host_wr_n(host_wr_n), .host_be(host_be), .host_wdata(host_wdata),
    .host_irq_pin_n(host_irq_pin_n), .cpu_ctl_wr(cpu_ctl_wr), .cpu_ctl_be(cpu_ctl_be),
    .cpu_ctl_wdata(cpu_ctl_wdata), .instr_done(instr_done), .nmi_taken(nmi_taken),
    .exec_halted(exec_halted), .cache_off(cache_off), .nmi_request(nmi_request),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack)
);

// File: verification/hpc_mem_model.sv
`timescale 1ns/1ps

module hpc_mem_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // local memory bus
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [1:0] cnt_r;
    logic slow_r;
    initial mem_ack = 1'b0;
    initial mem_rdata = 16'h0000;
    // alternating fast and slow answers; data changes every idle cycle
    always @(posedge sys_clk) begin
        mem_ack <= 1'b0;
        if (reset) begin
            cnt_r <= 2'h0;
            slow_r <= 1'b0;
        end else if (mem_req && !mem_ack) begin
            if (cnt_r == (slow_r ? 2'h3 : 2'h1)) begin
                mem_ack <= 1'b1;
                mem_rdata <= mem_addr[19:4] ^ 16'h5A5A;
                cnt_r <= 2'h0;
                slow_r <= ~slow_r;
            end else begin
                cnt_r <= cnt_r + 2'h1;
            end
        end else if (!mem_req) begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// File: verification/hpc_host_port_test.sv
`timescale 1ns/1ps

module hpc_host_port_test;
    import hpc_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, host_cs_n = 1'b1;
    logic func_select_0 = 1'b0, func_select_1 = 1'b0, host_rd_n = 1'b1, host_wr_n = 1'b1;
    logic cpu_ctl_wr = 1'b0, instr_done = 1'b0, nmi_taken = 1'b0;
    logic [1:0] host_be = 2'h0, cpu_ctl_be = 2'h0;
    logic [15:0] host_wdata = 16'h0000, cpu_ctl_wdata = 16'h0000;
    logic [15:0] host_rdata, cpu_ctl_rdata, mem_wdata, mem_rdata, cap_wd;
    logic host_irq_pin_n, pending_from_host_flag, exec_halted, cache_off, nmi_request;
    logic nmi_no_save, mem_req, mem_we, mem_ack, cap_we;
    logic [31:0] mem_addr, cap_addr;
    int bad_count = 0, checks = 0;

    always #5 sys_clk = ~sys_clk;

    hpc_host_port DUT (
        .sys_clk(sys_clk), .reset(reset), .host_cs_n(host_cs_n),
        .func_select_0(func_select_0), .func_select_1(func_select_1),
        .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_be(host_be),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_irq_pin_n(host_irq_pin_n),
        .cpu_ctl_wr(cpu_ctl_wr), .cpu_ctl_be(cpu_ctl_be), .cpu_ctl_wdata(cpu_ctl_wdata),
        .cpu_ctl_rdata(cpu_ctl_rdata), .pending_from_host_flag(pending_from_host_flag),
        .instr_done(instr_done), .nmi_taken(nmi_taken), .exec_halted(exec_halted),
        .cache_off(cache_off), .nmi_request(nmi_request), .nmi_no_save(nmi_no_save),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack)
    );
    hpc_mem_model u_mem (.sys_clk(sys_clk), .reset(reset), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    // ==========================================
    // shared tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // strobes held for exactly one edge, then one idle edge
    task automatic hacc(input hpc_sel_t s, input logic rd, input logic [1:0] be,
        input logic [15:0] d);
        {func_select_1, func_select_0} = s;
        host_be = be;
        host_wdata = d;
        host_cs_n = 1'b0;
        host_rd_n = ~rd;
        host_wr_n = rd;
        tick(1);
        host_cs_n = 1'b1;
        host_rd_n = 1'b1;
        host_wr_n = 1'b1;
        tick(1);
    endtask
    task automatic cwr(input logic [1:0] be, input logic [15:0] d);
        cpu_ctl_be = be;
        cpu_ctl_wdata = d;
        cpu_ctl_wr = 1'b1;
        tick(1);
        cpu_ctl_wr = 1'b0;
        tick(1);
    endtask
    // captures one memory cycle; the port stays busy one cycle after ack
    task automatic wmem();
        int n;
        n = 0;
        while (mem_req !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk(mem_req, 1'b1);
        cap_addr = mem_addr;
        cap_we = mem_we;
        cap_wd = mem_wdata;
        while (mem_req === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        tick(3);
    endtask

    // ==========================================
    // scenarios
    task automatic t_ctl();
        chk({host_irq_pin_n, mem_req, exec_halted}, 3'h4);
        hacc(HPC_SEL_CTL, 1'b1, 2'h3, 16'h0000);
        chk(host_rdata, HPC_CTL_RESET);
        hacc(HPC_SEL_CTL, 1'b0, 2'h3, 16'hFEFD);
        chk({cache_off, nmi_no_save, pending_from_host_flag}, 3'h7);
        chk({host_irq_pin_n, exec_halted}, 2'h2);
        instr_done = 1'b1;
        tick(1);
        instr_done = 1'b0;
        chk(exec_halted, 1'b1);
        hacc(HPC_SEL_CTL, 1'b1, 2'h3, 16'h0000);
        chk(host_rdata, 16'hFA0D);
        $display("t_ctl done");
    endtask
    task automatic t_cpu();
        cwr(2'h1, 16'h00F7);
        chk({host_irq_pin_n, pending_from_host_flag}, 2'h0);
        chk(cpu_ctl_rdata[7:0], 8'hF5);
        cwr(2'h1, 16'h0070);
        chk(host_irq_pin_n, 1'b0);
        hacc(HPC_SEL_CTL, 1'b0, 2'h1, 16'h0000);
        chk(host_irq_pin_n, 1'b1);
        hacc(HPC_SEL_CTL, 1'b1, 2'h3, 16'h0000);
        chk(host_rdata[7:0], 8'h70);
        $display("t_cpu done");
    endtask
    task automatic t_nmi();
        hacc(HPC_SEL_CTL, 1'b0, 2'h2, 16'h0100);
        chk({nmi_request, exec_halted, cache_off}, 3'h4);
        cwr(2'h2, 16'h0000);
        chk(nmi_request, 1'b1);
        nmi_taken = 1'b1;
        tick(1);
        nmi_taken = 1'b0;
        tick(1);
        chk(nmi_request, 1'b0);
        $display("t_nmi done");
    endtask
    task automatic t_rd();
        hacc(HPC_SEL_PTR_LO, 1'b0, 2'h3, 16'h123F);
        chk(mem_req, 1'b0);
        hacc(HPC_SEL_PTR_HI, 1'b0, 2'h3, 16'hABCD);
        wmem();
        chk({cap_we, cap_addr}, {1'b0, 32'hABCD1230});
        hacc(HPC_SEL_DATA, 1'b1, 2'h3, 16'h0000);
        chk(host_rdata, 16'hD123 ^ 16'h5A5A);
        wmem();
        chk(cap_addr, 32'hABCD1230);
        hacc(HPC_SEL_CTL, 1'b0, 2'h2, 16'h1000);
        hacc(HPC_SEL_DATA, 1'b1, 2'h3, 16'h0000);
        wmem();
        chk(cap_addr, 32'hABCD1240);
        $display("t_rd done");
    endtask
    task automatic t_wr();
        hacc(HPC_SEL_CTL, 1'b0, 2'h2, 16'h2800);
        hacc(HPC_SEL_PTR_HI, 1'b0, 2'h3, 16'h0040);
        chk(mem_req, 1'b0);
        hacc(HPC_SEL_PTR_LO, 1'b0, 2'h3, 16'h0005);
        wmem();
        chk({cap_we, cap_addr}, {1'b0, 32'h00400000});
        hacc(HPC_SEL_DATA, 1'b0, 2'h2, 16'hBE00);
        chk(mem_req, 1'b0);
        hacc(HPC_SEL_DATA, 1'b0, 2'h1, 16'h00EF);
        wmem();
        chk({cap_we, cap_addr, cap_wd}, {1'b1, 32'h00400000, 16'hBEEF});
        hacc(HPC_SEL_DATA, 1'b0, 2'h3, 16'h1234);
        wmem();
        chk({cap_addr, cap_wd}, {32'h00400010, 16'h1234});
        $display("t_wr done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
    initial begin
        tick(8);
        reset = 1'b0;
        t_ctl();
        t_cpu();
        t_nmi();
        t_rd();
        t_wr();
        end_of_test();
    end
endmodule
